//--- hw/burst_ram_if.sv
// Notes on behaviour
// - After power-up the mode is async page read and async write.
// - Mode pin low 0.5 us in standby, refresh set: subset refresh.
// - Mode pin high during subset refresh returns straight to standby.
// - Mode field 00 is async, 10 is synchronous burst read and write.
// - Async mode ignores clock and address valid; wait pin undriven.
// - Register write takes refresh, length, order, latency from address.
// - Register write takes wait polarity, mode, drive strength too.
// - Address bits 18 to 22 are ignored by a register write.
// - A reserved code in a field loads that field's default.
// - Register write within 0.5 us of mode pin fall, else refresh.
// - Async read on chip select, output and byte enable low; pages.
// - Async write starts with chip select, write enable, byte enable low.
// - Async write in sync mode: address valid either way; a clock edge with it low opens a burst.
// - Bursts of 4, 8, 16 and 256 words, linear or interleaved.
// - First data after latency of four or five clocks.
// - Stopped clock suspends a burst, which resumes on the next edge.
// - Burst write skips a byte whose enable is high.
// - Address latched at first burst clock edge; write enable low writes.
// - Wait pin active, in set polarity, one clock before each data word.
// - Linear wraps within length; interleaved xors offset with word count.
`default_nettype none
`include "burst_ram_params.svh"

module burst_ram_if #(
  parameter int unsigned PWRUP_CYCLES = `PWRUP_CYC,
  parameter int unsigned MEM_AW       = 8
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Pins from the host
  input  wire burst_ram_pkg::pins_s pins_in,
  // Data pins back to the host
  output logic [15:0]               dq_out,
  output logic [1:0]                dq_oe,
  // Wait pin
  output logic                      data_hold_off_n_pin,
  output logic                      data_hold_off_n_oe,
  // Status
  output logic                      powered_ready,
  output logic                      subset_refresh_active,
  output burst_ram_pkg::cfg_s       mode_cfg
);
  import burst_ram_pkg::*;

  localparam logic [7:0] MRS_WIN = 8'(`MRS_WIN_CYC);
  localparam int         MEM_N   = 2 ** MEM_AW;

  // ---------------------------------------------------------------
  // Field decode with reserved-code fallback
  // ---------------------------------------------------------------
  function automatic cfg_s decode_cfg(input logic [`CFG_MSB:0] a);
    cfg_s c;
    c = cfg_s'(a);
    c.rsvd = 1'b0;
    if (c.burst_len_field != `BLEN_4 && c.burst_len_field != `BLEN_8 &&
        c.burst_len_field != `BLEN_16 &&
        c.burst_len_field != `BLEN_256) begin
      c.burst_len_field = `RST_BLEN;
    end
    if (c.latency_field != `LAT_4 && c.latency_field != `LAT_5) begin
      c.latency_field = `RST_LAT;
    end
    if (c.op_mode_field != `MODE_ASYNC && c.op_mode_field != `MODE_SYNC) begin
      c.op_mode_field = `RST_MODE;
    end
    if (c.drive_strength_field == `DRIVE_RSVD) begin
      c.drive_strength_field = `RST_DRIVE;
    end
    if (c.par_field[4:3] == `PAR_RSVD) begin
      c.par_field = `RST_PAR;
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Pin capture
  // ---------------------------------------------------------------
  pins_s p;

  pin_sync #(
    .W   ($bits(pins_s)),
    .RST (PINS_IDLE)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_d   (pins_in),
    .pin_q   (p)
  );

  state_e           st_q, st_d;
  cfg_s             cfg_q;
  logic             bclk_q;
  logic [31:0]      pwr_cnt_q;
  logic [7:0]       mrs_cnt_q;
  logic             mrs_act_q;
  logic [`CFG_MSB:0] mrs_addr_q;
  logic [22:0]      addr_lat_q;
  logic             awr_q;
  logic [22:0]      aw_addr_q;
  logic [15:0]      aw_data_q;
  logic [1:0]       aw_mask_q;
  logic [22:0]      b_start_q;
  logic             b_write_q;
  logic [8:0]       b_cnt_q;
  logic             b_dval_q;
  logic             b_done_q;
  logic             wait_act_q;
  logic [15:0]      dq_q;
  logic [1:0]       dq_oe_q;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  wire        be_any    = ~p.upper_byte_en_n | ~p.lower_byte_en_n;
  wire [1:0]  be_vec    = ~{p.upper_byte_en_n, p.lower_byte_en_n};
  wire        sync_mode = cfg_q.op_mode_field == `MODE_SYNC;
  wire        bclk_rise = p.burst_clk & ~bclk_q;
  wire        idle      = st_q == ST_IDLE;
  wire        par_en    = cfg_q.par_field[4] & ~cfg_q.par_field[3];
  // Register write strobe: every control low except output enable
  wire        mrs_act   = st_q != ST_PWRUP & ~p.chip_select_n &
                          ~p.address_valid_n & ~p.write_enable_n &
                          ~p.upper_byte_en_n & ~p.lower_byte_en_n &
                          ~p.mode_set_pin_n & p.output_enable_n;
  wire        mrs_commit = mrs_act_q & ~mrs_act;
  // Async read; clock and address valid play no part
  wire        ard       = idle & ~p.chip_select_n & ~p.output_enable_n &
                          p.write_enable_n & p.mode_set_pin_n & be_any;
  // Async write, also allowed while burst mode is selected
  wire        awr       = idle & ~p.chip_select_n & ~p.write_enable_n &
                          p.mode_set_pin_n & p.output_enable_n & be_any;
  // A burst opened over a pending write wins; no stray commit follows
  wire        aw_end    = awr_q & ~awr & idle;
  // Address valid is only honoured in sync mode; low means transparent
  wire [22:0] addr_now  = (sync_mode & p.address_valid_n) ? addr_lat_q
                                                           : p.addr;
  // A clock edge while address valid is low opens a burst
  wire        bcmd      = idle & sync_mode & bclk_rise & ~p.chip_select_n &
                          ~p.address_valid_n & p.mode_set_pin_n;

  // ---------------------------------------------------------------
  // Burst sequencing
  // ---------------------------------------------------------------
  wire [8:0]  b_lat  = (cfg_q.latency_field == `LAT_4) ? 9'h004
                                                       : 9'h005;
  wire [7:0]  b_mask = (cfg_q.burst_len_field == `BLEN_4)  ? 8'h03 :
                       (cfg_q.burst_len_field == `BLEN_8)  ? 8'h07 :
                       (cfg_q.burst_len_field == `BLEN_16) ? 8'h0f
                                                           : 8'hff;
  wire        on_edge = st_q == ST_BURST & bclk_rise;
  wire [8:0]  n_edge  = b_cnt_q + 9'h001;
  wire        word_ok = n_edge >= b_lat;
  wire [7:0]  w_idx   = 8'(n_edge - b_lat);
  wire [7:0]  b_off   = b_start_q[7:0] & b_mask;
  // Linear wraps inside the length, interleave xors the offset
  wire [7:0]  b_seq   = cfg_q.burst_order_field ? (b_off ^ w_idx)
                                                : 8'(b_off + w_idx);
  wire [22:0] b_addr  = {b_start_q[22:8],
                         (b_start_q[7:0] & ~b_mask) | (b_seq & b_mask)};
  wire        b_last  = word_ok & (w_idx == b_mask);
  wire        bwr     = on_edge & b_write_q & word_ok & ~b_done_q;
  wire        brd     = on_edge & ~b_write_q & word_ok & ~b_done_q;

  // ---------------------------------------------------------------
  // Storage, one byte lane per generate pass
  // ---------------------------------------------------------------
  wire              mem_we = aw_end | bwr;
  wire [22:0]       mem_wa = aw_end ? aw_addr_q : b_addr;
  wire [15:0]       mem_wd = aw_end ? aw_data_q : p.dq;
  wire [1:0]        mem_wm = aw_end ? aw_mask_q : be_vec;
  wire [22:0]       mem_ra = (st_q == ST_BURST) ? b_addr : addr_now;
  wire [15:0]       rd_word;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [7:0] lane_q [MEM_N];
      // Masked bytes keep their old contents
      always_ff @(posedge clk) begin
        if (mem_we & mem_wm[g]) begin
          lane_q[mem_wa[MEM_AW-1:0]] <= mem_wd[8*g +: 8];
        end
      end
      assign rd_word[8*g +: 8] = lane_q[mem_ra[MEM_AW-1:0]];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------
  // Next state; standby is idle with chip select high
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_PWRUP: begin
        if (pwr_cnt_q >= 32'(PWRUP_CYCLES - 1) & p.chip_select_n &
            p.mode_set_pin_n) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (~p.mode_set_pin_n & p.chip_select_n) begin
          st_d = ST_MRS;
        end else if (bcmd) begin
          st_d = ST_BURST;
        end
      end
      ST_MRS: begin
        if (p.mode_set_pin_n & ~mrs_act_q) begin
          st_d = ST_IDLE;
        end else if (p.chip_select_n & ~mrs_act_q & par_en &
                     mrs_cnt_q >= MRS_WIN - 8'h01) begin
          st_d = ST_PAR;
        end
      end
      ST_PAR: begin
        if (p.mode_set_pin_n) begin
          st_d = ST_IDLE;
        end
      end
      ST_BURST: begin
        if (p.chip_select_n | (on_edge & b_done_q)) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_PWRUP;
    endcase
  end

  // State, timers and mode register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q       <= ST_PWRUP;
      pwr_cnt_q  <= 32'h0;
      mrs_cnt_q  <= 8'h00;
      bclk_q     <= 1'b0;
      cfg_q      <= '{`RST_DRIVE, `RST_MODE, `RST_WPOL, 1'b0, `RST_LAT,
                      `RST_ORDER, `RST_BLEN, `RST_PAR};
      mrs_act_q  <= 1'b0;
      mrs_addr_q <= '0;
    end else begin
      st_q      <= st_d;
      bclk_q    <= p.burst_clk;
      pwr_cnt_q <= (st_q == ST_PWRUP & p.chip_select_n &
                    p.mode_set_pin_n) ? pwr_cnt_q + 32'h1 : 32'h0;
      mrs_cnt_q <= (st_q == ST_MRS & p.chip_select_n & mrs_cnt_q != 8'hff)
                   ? mrs_cnt_q + 8'h01 : (st_q == ST_MRS & p.chip_select_n)
                   ? mrs_cnt_q : 8'h00;
      mrs_act_q <= mrs_act;
      if (mrs_act) begin
        mrs_addr_q <= p.addr[`CFG_MSB:0];
      end
      if (mrs_commit) begin
        cfg_q <= decode_cfg(mrs_addr_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // Access registers
  // ---------------------------------------------------------------
  // Address latch and async write capture, committed at strobe end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_lat_q <= 23'h0;
      awr_q      <= 1'b0;
      aw_addr_q  <= 23'h0;
      aw_data_q  <= 16'h0;
      aw_mask_q  <= 2'h0;
    end else begin
      if (~p.address_valid_n) begin
        addr_lat_q <= p.addr;
      end
      awr_q <= awr;
      if (awr) begin
        aw_addr_q <= addr_now;
        aw_data_q <= p.dq;
        aw_mask_q <= be_vec;
      end
    end
  end

  // Burst progress; only the exit clear moves without a clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_start_q  <= 23'h0;
      b_write_q  <= 1'b0;
      b_cnt_q    <= 9'h000;
      b_dval_q   <= 1'b0;
      b_done_q   <= 1'b0;
      wait_act_q <= 1'b0;
    end else if (bcmd) begin
      b_start_q  <= p.addr;
      b_write_q  <= ~p.write_enable_n;
      b_cnt_q    <= 9'h000;
      b_dval_q   <= 1'b0;
      b_done_q   <= 1'b0;
      wait_act_q <= b_lat <= 9'h001;
    end else if (st_d != ST_BURST) begin
      b_dval_q   <= 1'b0;
      wait_act_q <= 1'b0;
    end else if (on_edge) begin
      b_cnt_q    <= n_edge;
      b_dval_q   <= b_dval_q | word_ok;
      b_done_q   <= b_done_q | b_last;
      // Raised one clock ahead of the word it announces
      wait_act_q <= (n_edge + 9'h001 >= b_lat) & ~b_last &
                    ~b_done_q;
    end
  end

  // Read data and byte-lane drive enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_q    <= 16'h0;
      dq_oe_q <= 2'h0;
    end else begin
      if (ard | brd) begin
        dq_q <= rd_word;
      end
      if (ard) begin
        dq_oe_q <= be_vec;
      end else if (st_q == ST_BURST & ~b_write_q & b_dval_q &
                   ~p.output_enable_n & ~p.chip_select_n) begin
        dq_oe_q <= be_vec;
      end else begin
        dq_oe_q <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign dq_out                = dq_q;
  assign dq_oe                 = dq_oe_q;
  assign data_hold_off_n_pin   = cfg_q.wait_polarity_field ? wait_act_q
                                                           : ~wait_act_q;
  // Released in async mode so a shared wait line stays free
  assign data_hold_off_n_oe    = sync_mode & ~p.chip_select_n &
                                 st_q != ST_PWRUP;
  assign powered_ready         = st_q != ST_PWRUP;
  assign subset_refresh_active = st_q == ST_PAR;
  assign mode_cfg              = cfg_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_par_exit_direct: assert property (
    st_q == ST_PAR && p.mode_set_pin_n |=> st_q == ST_IDLE)
    else $error("subset refresh not left on mode pin high");
  a_par_entry_wait: assert property (
    $rose(st_q == ST_PAR) |-> $past(mrs_cnt_q) >= MRS_WIN - 8'h01 && par_en)
    else $error("subset refresh entered too early");
  a_reserved_len_default: assert property (
    mrs_commit && mrs_addr_q[7:5] == 3'h0 |=>
      mode_cfg.burst_len_field == `RST_BLEN)
    else $error("reserved burst length not defaulted");
  a_mode_sync_select: assert property (
    mrs_commit && mrs_addr_q[15:14] == 2'h2 |=> sync_mode[*2])
    else $error("sync mode code not applied");
  a_async_wait_hiz: assert property (
    !sync_mode |-> !data_hold_off_n_oe)
    else $error("wait pin driven in async mode");
  a_wait_lead_data: assert property (
    $rose(b_dval_q) |-> $past(wait_act_q))
    else $error("wait not active a clock before data");
  a_first_latency: assert property (
    $rose(b_dval_q) |-> b_cnt_q == b_lat)
    else $error("first word at wrong latency");
  a_suspend_hold: assert property (
    st_q == ST_BURST && !bclk_rise && !p.chip_select_n |=> $stable(b_cnt_q))
    else $error("burst advanced without clock edge");
  a_pwrup_hold: assert property (
    st_q == ST_PWRUP && !(p.chip_select_n && p.mode_set_pin_n) |=>
      st_q == ST_PWRUP)
    else $error("left power-up with strobes low");

  c_par_entered:   cover property ($rose(st_q == ST_PAR));
  c_mrs_written:   cover property (mrs_commit);
  c_burst_rd_last: cover property (brd && b_last);
  c_async_wr_done: cover property (aw_end && sync_mode);

endmodule

`default_nettype wire

//--- hw/burst_ram_params.svh
`ifndef BURST_RAM_PARAMS_SVH
`define BURST_RAM_PARAMS_SVH

// ---------------------------------------------------------------
// Mode register field positions on the address pins
// ---------------------------------------------------------------
`define PAR_LSB      0
`define BLEN_LSB     5
`define ORDER_BIT    8
`define LAT_LSB      9
`define RSVD_BIT     12
`define WPOL_BIT     13
`define MODE_LSB     14
`define DRIVE_LSB    16
`define CFG_MSB      17

// ---------------------------------------------------------------
// Field codes and their defaults after power-up
// ---------------------------------------------------------------
`define BLEN_4       3'h2
`define BLEN_8       3'h3
`define BLEN_16      3'h4
`define BLEN_256     3'h7
`define LAT_4        3'h4
`define LAT_5        3'h5
`define MODE_ASYNC   2'h0
`define MODE_SYNC    2'h2
`define DRIVE_RSVD   2'h3
`define PAR_RSVD     2'h3
`define RST_PAR      5'h00
`define RST_BLEN     3'h2
`define RST_ORDER    1'h0
`define RST_LAT      3'h5
`define RST_WPOL     1'h0
`define RST_MODE     2'h0
`define RST_DRIVE    2'h1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ      200
`define PWRUP_US     200
`define PWRUP_CYC    (`PWRUP_US * `CLK_MHZ)
`define MRS_WIN_NS   500
`define MRS_WIN_CYC  ((`MRS_WIN_NS * `CLK_MHZ + 999) / 1000)

`endif

//--- hw/burst_ram_pkg.sv
`default_nettype none

package burst_ram_pkg;

  // ---------------------------------------------------------------
  // Mode register image, packed at its address-bit positions
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] drive_strength_field;
    logic [1:0] op_mode_field;
    logic       wait_polarity_field;
    logic       rsvd;
    logic [2:0] latency_field;
    logic       burst_order_field;
    logic [2:0] burst_len_field;
    logic [4:0] par_field;
  } cfg_s;

  // Raw pin levels as seen at the balls
  typedef struct packed {
    logic [22:0] addr;
    logic [15:0] dq;
    logic        chip_select_n;
    logic        address_valid_n;
    logic        output_enable_n;
    logic        write_enable_n;
    logic        upper_byte_en_n;
    logic        lower_byte_en_n;
    logic        mode_set_pin_n;
    logic        burst_clk;
  } pins_s;

  // Bus at rest: strobes high, clock low
  localparam pins_s PINS_IDLE = '{addr: 23'h0, dq: 16'h0,
                                  burst_clk: 1'b0, default: 1'b1};

  typedef enum logic [4:0] {
    ST_PWRUP = 5'h01,
    ST_IDLE  = 5'h02,
    ST_MRS   = 5'h04,
    ST_PAR   = 5'h08,
    ST_BURST = 5'h10
  } state_e;

endpackage

`default_nettype wire

//--- hw/pin_sync.sv
`default_nettype none

module pin_sync #(
  parameter int unsigned     W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Pin levels in and filtered levels out
  input  wire logic [W-1:0]  pin_d,
  output logic      [W-1:0]  pin_q
);

  // ---------------------------------------------------------------
  // Three stages per bit; a change counts once stages 2 and 3 agree
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic q_q;
      // Stage 1 feeds stage 2 only, to keep metastability contained
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_q <= RST[i];
          s2_q <= RST[i];
          s3_q <= RST[i];
          q_q  <= RST[i];
        end else begin
          s1_q <= pin_d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            q_q <= s3_q;
          end
        end
      end
      assign pin_q[i] = q_q;
    end
  endgenerate

endmodule

`default_nettype wire

//--- testbench/host_drv.sv
`default_nettype none

module host_drv (
  // Clock
  input  wire logic                clk,
  // Pins toward the device
  output var burst_ram_pkg::pins_s pins
);
  import burst_ram_pkg::*;

  // -------------------------------------------------------------
  // Pin driver
  // -------------------------------------------------------------
  // Chip select and mode pin high from power-on
  initial pins = PINS_IDLE;

  // Strobes as {cs, adv, oe, we, ub, lb, mode}; burst clock parked low
  task automatic put(input logic [6:0] s, input logic [22:0] a,
                     input logic [15:0] d);
    @(posedge clk);
    pins <= '{addr: a, dq: d, chip_select_n: s[6], address_valid_n: s[5],
              output_enable_n: s[4], write_enable_n: s[3],
              upper_byte_en_n: s[2], lower_byte_en_n: s[1],
              mode_set_pin_n: s[0], burst_clk: 1'b0};
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Slow burst clock: each phase spans four clk so the sync stages see it
  task automatic bclk(input int n);
    repeat (n) begin
      @(posedge clk);
      pins.burst_clk <= 1'b1;
      idle(4);
      pins.burst_clk <= 1'b0;
      idle(3);
    end
  endtask

  // Mode pin first, strobes one clock later, far inside the window
  task automatic mode_wr(input logic [22:0] a);
    put(7'h7e, a, 16'h0000);
    put(7'h10, a & 23'h7fefff, 16'h0000);
    idle(8);
    put(7'h7f, a, 16'hffff);
    idle(8);
  endtask

  // Mode pin and output enable stay high through the write
  task automatic wr(input logic [22:0] a, input logic [15:0] d,
                    input logic ub, lb, adv);
    put({2'h0 | adv, 2'h2, ub, lb, 1'h1}, a, d);
    idle(8);
    put(7'h7f, a, ~d);
    idle(8);
  endtask

  // Mode pin and write enable stay high through the read
  task automatic rd(input logic [22:0] a, input logic ub, lb);
    put({4'h5, ub, lb, 1'h1}, a, 16'h0000);
    idle(6);
  endtask
endmodule

`default_nettype wire

//--- testbench/test_burst_ram_mode_async_access.sv
`default_nettype none

module test_burst_ram_mode_async_access;
  timeunit 1ns;
  timeprecision 1ps;
  import burst_ram_pkg::*;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  pins_s       pins;
  logic [15:0] dq_out;
  logic [1:0]  dq_oe;
  logic        hold_pin;
  logic        hold_oe;
  logic        powered_ready;
  logic        subset_refresh_active;
  cfg_s        mode_cfg;
  int          err_total = 0;
  int          cmp_count = 0;

  // Full register image with stray upper address bits set
  localparam logic [22:0] CFG_A = {5'h1f, 2'h2, 2'h2, 1'h1, 1'h0, 3'h4,
                                   1'h1, 3'h7, 5'h10};
  // Reserved codes in every field that has them
  localparam logic [22:0] CFG_B = {5'h00, 2'h3, 2'h3, 1'h0, 1'h0, 3'h7,
                                   1'h0, 3'h0, 5'h18};
  localparam logic [17:0] CFG_DEF = {2'h1, 2'h0, 1'h0, 1'h0, 3'h5, 1'h0,
                                     3'h2, 5'h00};

  always #2.5 clk = ~clk;

  host_drv host (.clk(clk), .pins(pins));

  burst_ram_if #(.PWRUP_CYCLES(20)) dut (
    .clk(clk), .sys_rst(sys_rst), .pins_in(pins),
    .dq_out(dq_out), .dq_oe(dq_oe),
    .data_hold_off_n_pin(hold_pin), .data_hold_off_n_oe(hold_oe),
    .powered_ready(powered_ready),
    .subset_refresh_active(subset_refresh_active),
    .mode_cfg(mode_cfg));

  // -------------------------------------------------------------
  // Checking and reporting
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [17:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is a few hundred clocks; this is far beyond it
  initial begin
    #100000;
    err_total++;
    final_report();
  end

  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("ready early", 18'h0, powered_ready);
    chk("default cfg", CFG_DEF, mode_cfg);
    for (int i = 0; i < 200 && powered_ready !== 1'b1; i++)
      @(posedge clk);
    chk("ready", 18'h1, powered_ready);
    $display("test power_up done");

    host.mode_wr(CFG_A);
    #1;
    chk("cfg a", CFG_A[17:0], mode_cfg);
    $display("test mode_write done");

    // Mode pin low in standby: nothing before the window expires
    host.put(7'h7e, 23'h0, 16'h0000);
    host.idle(60);
    #1;
    chk("refresh early", 18'h0, subset_refresh_active);
    host.idle(60);
    #1;
    chk("refresh on", 18'h1, subset_refresh_active);
    host.put(7'h7f, 23'h0, 16'h0000);
    host.idle(8);
    #1;
    chk("refresh off", 18'h0, subset_refresh_active);
    $display("test subset_refresh done");

    // Write in burst mode with address valid held low, clock still
    host.wr(23'h20, 16'hbeef, 1'b0, 1'b0, 1'b0);
    // Interleaved burst from 0x21: second word comes from 0x20
    host.put(7'h09, 23'h21, 16'h0000);
    host.bclk(6);
    #1;
    chk("burst word 1", 18'hbeef, dq_out);
    chk("burst lanes", 18'h3, dq_oe);
    chk("wait active", 18'h1, hold_pin);
    chk("wait driven", 18'h1, hold_oe);
    host.put(7'h7f, 23'h0, 16'h0000);
    host.idle(8);
    #1;
    chk("wait released", 18'h0, hold_oe);
    $display("test burst_read done");
    host.mode_wr(CFG_B);
    #1;
    chk("cfg reserved", CFG_DEF, mode_cfg);
    $display("test reserved_codes done");

    host.wr(23'h21, 16'h1234, 1'b0, 1'b0, 1'b1);
    host.wr(23'h21, 16'hffaa, 1'b1, 1'b0, 1'b1);
    host.rd(23'h20, 1'b0, 1'b0);
    #1;
    chk("word 0", 18'hbeef, dq_out);
    chk("lanes 0", 18'h3, dq_oe);
    chk("wait oe", 18'h0, hold_oe);
    host.rd(23'h21, 1'b0, 1'b0);
    #1;
    chk("page word", 18'h12aa, dq_out);
    host.rd(23'h21, 1'b0, 1'b1);
    #1;
    chk("upper lane", 18'h2, dq_oe);
    host.put(7'h7f, 23'h0, 16'h0000);
    host.idle(8);
    #1;
    chk("lanes off", 18'h0, dq_oe);
    $display("test async_access done");
    final_report();
  end
endmodule

`default_nettype wire
